/* File: hw/usart_rx_ctrl.sv */
// usart_rx_ctrl: receive control and status of a serial port with an
// AXI4-Lite register slave, a one-character receive buffer and error flags
// assumes line inputs synchronous to clk and one AXI master
//
// How it works
// - async: receive characters while continuous enable is set, else stop
// - sync: continuous enable keeps receiving and overrides single enable
// - 9-bit async, address detect on: keep only characters with ninth bit 1
// - address detect off: keep every character; ninth bit left for software
// - framing flag follows each character loaded after a buffer read
// - overrun flag sets on overrun, clears when continuous enable is cleared
// - single enable receives one character in sync master, ignored in slave
// - single enable clears itself when the single reception completes
`timescale 1ns/1ps
module usart_rx_ctrl #(
    parameter int BIT_CLKS = usart_rx_pkg::BIT_CLKS_DEF
) (
    // clock and reset
    input  wire logic                              clk,
    input  wire logic                              srst,
    // axi4-lite write
    input  wire logic [usart_rx_pkg::ADDR_W-1:0]   awaddr,
    input  wire logic                              awvalid,
    output logic                                   awready,
    input  wire logic [usart_rx_pkg::DATA_W-1:0]   wdata,
    input  wire logic [3:0]                        wstrb,
    input  wire logic                              wvalid,
    output logic                                   wready,
    output logic [1:0]                             bresp,
    output logic                                   bvalid,
    input  wire logic                              bready,
    // axi4-lite read
    input  wire logic [usart_rx_pkg::ADDR_W-1:0]   araddr,
    input  wire logic                              arvalid,
    output logic                                   arready,
    output logic [usart_rx_pkg::DATA_W-1:0]        rdata,
    output logic [1:0]                             rresp,
    output logic                                   rvalid,
    input  wire logic                              rready,
    // serial line
    input  wire logic                              rx_in,
    input  wire logic                              sck_in,
    output logic                                   sck_out,
    output logic                                   sck_oe,
    // buffer holds an unread character
    output logic                                   rx_char_ready
);
    import usart_rx_pkg::*;

    function automatic reg_sel_e decode(input logic [ADDR_W-1:0] a);
        case (a)
            CTRL_OFS: decode = SEL_CTRL;
            DATA_OFS: decode = SEL_DATA;
            MODE_OFS: decode = SEL_MODE;
            STAT_OFS: decode = SEL_STAT;
            default:  decode = SEL_NONE;
        endcase
    endfunction : decode

    logic              continuous_rx_enable_q, single_rx_enable_q, aden_q, rx9_q, sync_q, master_q;
    logic              ovr_q, frm_q, full_q;
    logic [CHAR_W-1:0] buf_q;
    logic              aw_hold_q, w_hold_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [3:0]        wstrb_q;
    logic              run, done, frame_err, wr_go, rd_go, pop;
    logic              accept, load, overrun, single_done, full_eff;
    logic [CHAR_W-1:0] char_data;
    reg_sel_e          wsel;

    // receive enable: continuous wins, single only as sync master
    always_comb begin
        if (!sync_q)
            run = continuous_rx_enable_q;
        else
            run = continuous_rx_enable_q || (single_rx_enable_q && master_q);
    end

    rx_shifter #(.BIT_CLKS(BIT_CLKS)) rx_shifter_i (
        .clk         (clk),
        .srst        (srst),
        .run         (run),
        .sync_mode   (sync_q),
        .master      (master_q),
        .nine_bit    (rx9_q),
        .rx_in       (rx_in),
        .sck_in      (sck_in),
        .sck_out     (sck_out),
        .done        (done),
        .data_q      (char_data),
        .frame_err_q (frame_err)
    );
    assign sck_oe = sync_q && master_q;

    // address filter applies only to 9-bit asynchronous reception
    assign accept = done && !(aden_q && rx9_q && !sync_q
                              && !char_data[CHAR_W-1]);
    // a read in the same cycle frees the buffer for the new character
    assign full_eff    = full_q && !pop;
    assign load        = accept && !full_eff;
    assign overrun     = accept && full_eff;
    assign single_done = done && sync_q && master_q && !continuous_rx_enable_q;
    assign rx_char_ready = full_q;

    // axi write channel: address and data taken in either order
    assign awready = !aw_hold_q && !bvalid;
    assign wready  = !w_hold_q && !bvalid;
    assign wr_go   = aw_hold_q && w_hold_q && !bvalid;
    assign wsel    = decode(awaddr_q);

    always_ff @(posedge clk) begin
        if (srst) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
            bvalid    <= 1'b0;
            bresp     <= RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_hold_q <= 1'b1;
                awaddr_q  <= awaddr;
            end
            if (wvalid && wready) begin
                w_hold_q <= 1'b1;
                wdata_q  <= wdata;
                wstrb_q  <= wstrb;
            end
            if (wr_go) begin
                aw_hold_q <= 1'b0;
                w_hold_q  <= 1'b0;
                bvalid    <= 1'b1;
                bresp     <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // software enables; single enable also cleared by hardware
    always_ff @(posedge clk) begin
        if (srst) begin
            continuous_rx_enable_q   <= 1'b0;
            single_rx_enable_q   <= 1'b0;
            aden_q   <= 1'b0;
            rx9_q    <= 1'b0;
            sync_q   <= 1'b0;
            master_q <= 1'b0;
        end else begin
            if (single_done)
                single_rx_enable_q <= 1'b0;
            if (wr_go && wstrb_q[0] && wsel == SEL_CTRL) begin
                continuous_rx_enable_q <= wdata_q[CONTINUOUS_RX_ENABLE_BIT];
                single_rx_enable_q <= wdata_q[SINGLE_RX_ENABLE_BIT];
                aden_q <= wdata_q[ADEN_BIT];
                rx9_q  <= wdata_q[RX9_BIT];
            end
            if (wr_go && wstrb_q[0] && wsel == SEL_MODE) begin
                sync_q   <= wdata_q[SYNC_BIT];
                master_q <= wdata_q[MASTER_BIT];
            end
        end
    end

    // axi read channel: one read at a time, answer one cycle after arvalid
    assign arready = !rvalid;
    assign rd_go   = arvalid && arready;
    assign pop     = rd_go && decode(araddr) == SEL_DATA;

    always_ff @(posedge clk) begin
        if (srst) begin
            rvalid <= 1'b0;
            rdata  <= '0;
            rresp  <= RESP_OKAY;
        end else if (rd_go) begin
            rvalid <= 1'b1;
            rdata  <= '0;
            rresp  <= RESP_OKAY;
            case (decode(araddr))
                SEL_CTRL: begin
                    rdata[CONTINUOUS_RX_ENABLE_BIT]  <= continuous_rx_enable_q;
                    rdata[SINGLE_RX_ENABLE_BIT]  <= single_rx_enable_q;
                    rdata[ADEN_BIT]  <= aden_q;
                    rdata[RX9_BIT]   <= rx9_q;
                    rdata[FRM_BIT]   <= frm_q;
                    rdata[OVR_BIT]   <= ovr_q;
                    rdata[NINTH_BIT] <= buf_q[CHAR_W-1];
                end
                SEL_DATA: rdata[CHAR_W-1:0] <= buf_q;
                SEL_MODE: begin
                    rdata[SYNC_BIT]   <= sync_q;
                    rdata[MASTER_BIT] <= master_q;
                end
                SEL_STAT: rdata[FULL_BIT] <= full_q;
                default:  rresp <= RESP_SLVERR;
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    // receive buffer and framing flag move together on each load
    always_ff @(posedge clk) begin
        if (srst) begin
            full_q <= 1'b0;
            buf_q  <= '0;
            frm_q  <= 1'b0;
        end else if (load) begin
            full_q <= 1'b1;
            buf_q  <= char_data;
            frm_q  <= frame_err;
        end else if (pop) begin
            full_q <= 1'b0;
        end
    end

    // overrun set wins over the clear by continuous enable low
    always_ff @(posedge clk) begin
        if (srst)
            ovr_q <= 1'b0;
        else if (overrun)
            ovr_q <= 1'b1;
        else if (!continuous_rx_enable_q)
            ovr_q <= 1'b0;
    end

    sequence seq_overrun;
        done && accept ##0 full_eff;
    endsequence
    sequence seq_filtered;
        done && !sync_q && rx9_q && aden_q && !char_data[CHAR_W-1];
    endsequence

    AST_ASYNC_RUN: assert property (@(posedge clk) disable iff (srst)
        !sync_q && !continuous_rx_enable_q |=> !done)
        else $error("async receiver delivered with continuous enable low");
    AST_SYNC_PRIO: assert property (@(posedge clk) disable iff (srst)
        sync_q && continuous_rx_enable_q && !single_done |=> !$fell(run) || !continuous_rx_enable_q)
        else $error("continuous receive stopped while enabled");
    AST_ADDR_DROP: assert property (@(posedge clk) disable iff (srst)
        seq_filtered |=> $stable(buf_q) && !$rose(full_q))
        else $error("filtered address character reached the buffer");
    AST_ACCEPT_ALL: assert property (@(posedge clk) disable iff (srst)
        done && !aden_q && !full_q |=> full_q && buf_q == $past(char_data))
        else $error("character lost with address detect off");
    AST_FRM_LOAD: assert property (@(posedge clk) disable iff (srst)
        load |=> frm_q == $past(frame_err))
        else $error("framing flag not updated on load");
    AST_OVR_HOLD: assert property (@(posedge clk) disable iff (srst)
        seq_overrun ##1 continuous_rx_enable_q [*2] |-> ovr_q)
        else $error("overrun flag not held");
    AST_OVR_CLR: assert property (@(posedge clk) disable iff (srst)
        !continuous_rx_enable_q && !overrun |=> !ovr_q)
        else $error("overrun flag not cleared by continuous enable low");
    AST_SLAVE_IGN: assert property (@(posedge clk) disable iff (srst)
        sync_q && !master_q && !continuous_rx_enable_q |=> !done)
        else $error("single enable acted in slave mode");
    AST_SINGLE_RX_ENABLE_DONE: assert property (@(posedge clk) disable iff (srst)
        single_done && !(wr_go && wsel == SEL_CTRL) |=> !single_rx_enable_q ##1 !done)
        else $error("single enable not cleared after reception");
    AST_DISCARD: assert property (@(posedge clk) disable iff (srst)
        seq_overrun |=> ovr_q && $stable(buf_q))
        else $error("overrun character overwrote buffer");
endmodule : usart_rx_ctrl

/* File: hw/usart_rx_pkg.sv */
// receive-side serial port constants: register map, field layout, timing
// assumes a 32-bit AXI4-Lite register bus and a 40 MHz system clock
package usart_rx_pkg;
    localparam int          DATA_W        = 32;
    localparam int          ADDR_W        = 8;
    // register byte addresses
    localparam logic [7:0]  CTRL_OFS      = 8'h00;
    localparam logic [7:0]  DATA_OFS      = 8'h04;
    localparam logic [7:0]  MODE_OFS      = 8'h08;
    localparam logic [7:0]  STAT_OFS      = 8'h0C;
    // control register fields
    localparam int          NINTH_BIT     = 0;
    localparam int          OVR_BIT       = 1;
    localparam int          FRM_BIT       = 2;
    localparam int          ADEN_BIT      = 3;
    localparam int          CONTINUOUS_RX_ENABLE_BIT      = 4;
    localparam int          SINGLE_RX_ENABLE_BIT      = 5;
    localparam int          RX9_BIT       = 6;
    // mode register fields
    localparam int          SYNC_BIT      = 0;
    localparam int          MASTER_BIT    = 1;
    // status register fields
    localparam int          FULL_BIT      = 0;
    localparam int          CHAR_W        = 9;
    // line timing
    localparam int          CLK_HZ        = 40_000_000;
    localparam int          BAUD_DEF      = 2_500_000;
    localparam int          BIT_CLKS_DEF  = CLK_HZ / BAUD_DEF;
    localparam int          CNT_W         = 16;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    typedef enum logic [2:0] {
        SEL_CTRL, SEL_DATA, SEL_MODE, SEL_STAT, SEL_NONE
    } reg_sel_e;
endpackage : usart_rx_pkg

/* File: hw/rx_shifter.sv */
// rx_shifter: assembles one character from the serial line
// assumes rx_in and sck_in are already synchronous to clk
`timescale 1ns/1ps
module rx_shifter #(
    parameter int BIT_CLKS = usart_rx_pkg::BIT_CLKS_DEF
) (
    // clock and reset
    input  wire logic                              clk,
    input  wire logic                              srst,
    // control
    input  wire logic                              run,
    input  wire logic                              sync_mode,
    input  wire logic                              master,
    input  wire logic                              nine_bit,
    // line
    input  wire logic                              rx_in,
    input  wire logic                              sck_in,
    output logic                                   sck_out,
    // result
    output logic                                   done,
    output logic [usart_rx_pkg::CHAR_W-1:0]        data_q,
    output logic                                   frame_err_q
);
    import usart_rx_pkg::*;

    localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(BIT_CLKS - 1);
    localparam logic [CNT_W-1:0] HALF_CNT = CNT_W'(BIT_CLKS / 2 - 1);

    typedef enum logic [1:0] {ST_IDLE, ST_START, ST_BITS, ST_STOP} st_e;

    st_e              st_q;
    logic [CNT_W-1:0] cnt_q;
    logic [3:0]       idx_q;
    logic [CHAR_W-1:0] sh_q;
    logic             sck_q;
    logic             sck_in_q;
    logic             tick;
    logic             sample;
    logic             last;

    assign tick    = (cnt_q == '0);
    assign last    = (idx_q == (nine_bit ? 4'(CHAR_W - 1) : 4'(CHAR_W - 2)));
    assign sck_out = sck_q;
    // sync master samples on its own rising edge, slave on the rising edge of sck_in
    always_comb begin
        if (!sync_mode)
            sample = tick;
        else if (master)
            sample = tick && !sck_q;
        else
            sample = sck_in && !sck_in_q;
    end

    always_ff @(posedge clk) begin
        if (srst)
            sck_in_q <= 1'b0;
        else
            sck_in_q <= sck_in;
    end

    always_ff @(posedge clk) begin
        if (srst || !run || st_q != ST_BITS || !sync_mode || !master)
            sck_q <= 1'b0;
        else if (tick)
            sck_q <= !sck_q;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_q        <= ST_IDLE;
            cnt_q       <= '0;
            idx_q       <= '0;
            sh_q        <= '0;
            done        <= 1'b0;
            data_q      <= '0;
            frame_err_q <= 1'b0;
        end else begin
            done  <= 1'b0;
            cnt_q <= tick ? (sync_mode ? HALF_CNT : FULL_CNT) : cnt_q - 1'b1;
            // dropping the enable abandons a partly assembled character
            if (!run) begin
                st_q <= ST_IDLE;
            end else begin
                case (st_q)
                    ST_IDLE: begin
                        idx_q <= '0;
                        sh_q  <= '0;
                        if (sync_mode) begin
                            st_q  <= ST_BITS;
                            cnt_q <= HALF_CNT;
                        end else if (!rx_in) begin
                            st_q  <= ST_START;
                            cnt_q <= HALF_CNT;
                        end
                    end
                    ST_START: begin
                        // a start bit gone high by mid-bit was a glitch
                        if (tick)
                            st_q <= rx_in ? ST_IDLE : ST_BITS;
                    end
                    ST_BITS: begin
                        if (sample) begin
                            sh_q[idx_q] <= rx_in;
                            idx_q       <= idx_q + 1'b1;
                            if (last && sync_mode) begin
                                st_q        <= ST_IDLE;
                                done        <= 1'b1;
                                frame_err_q <= 1'b0;
                                data_q      <= sh_q;
                                data_q[idx_q] <= rx_in;
                            end else if (last) begin
                                st_q <= ST_STOP;
                            end
                        end
                    end
                    ST_STOP: begin
                        if (tick) begin
                            st_q        <= ST_IDLE;
                            done        <= 1'b1;
                            data_q      <= sh_q;
                            frame_err_q <= !rx_in;
                        end
                    end
                    default: st_q <= ST_IDLE;
                endcase
            end
        end
    end
endmodule : rx_shifter

/* File: sim/serial_line_model.sv */
// serial_line_model: far end of the receive line, an async sender and a
// sync peer; assumes its tasks are called just after a rising clk edge
`timescale 1ns/1ps
module serial_line_model #(
    parameter int BIT_CLKS = 4
) (
    // clock
    input  wire logic clk,
    // clock driven by the device in sync master mode
    input  wire logic sck_out,
    input  wire logic sck_oe,
    // lines toward the device
    output logic      rx_in,
    output logic      sck_in
);
    logic bits[$];
    logic sck_prev;

    initial begin
        rx_in    = 1'b1;
        sck_in   = 1'b0;
        sck_prev = 1'b0;
    end

    // next bit goes out after the falling clock edge so that it is steady
    // when the device samples on the rising edge
    always @(posedge clk) begin
        sck_prev <= sck_out;
        if (sck_oe && sck_prev && !sck_out) begin
            if (bits.size() > 0)
                rx_in <= bits.pop_front();
            else
                rx_in <= !rx_in; // nothing left to send: line keeps moving
        end
    end

    // start, n data bits lsb first, stop at the given level, one idle bit
    task automatic send_async(input logic [8:0] d, input int n,
                              input logic stop);
        rx_in <= 1'b0;
        repeat (BIT_CLKS) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            rx_in <= d[i];
            repeat (BIT_CLKS) @(posedge clk);
        end
        rx_in <= stop;
        repeat (BIT_CLKS) @(posedge clk);
        rx_in <= 1'b1;
        repeat (BIT_CLKS) @(posedge clk);
    endtask : send_async

    task automatic sync_load(input logic [15:0] d, input int n);
        rx_in <= d[0];
        for (int i = 1; i < n; i++)
            bits.push_back(d[i]);
    endtask : sync_load

    // acts as sync master toward a slave device
    task automatic send_slave(input logic [7:0] d);
        for (int i = 0; i < 8; i++) begin
            rx_in <= d[i];
            repeat (2) @(posedge clk);
            sck_in <= 1'b1;
            repeat (2) @(posedge clk);
            sck_in <= 1'b0;
        end
        rx_in <= !d[7];
        repeat (2) @(posedge clk);
    endtask : send_slave
endmodule : serial_line_model

/* File: sim/usart_receive_control_status_test.sv */
// usart_receive_control_status_test: register-level receive tests
// assumes usart_rx_pkg, the design and serial_line_model compiled first
`timescale 1ns/1ps
module usart_receive_control_status_test;
    import usart_rx_pkg::*;

    localparam int          BC  = 4;
    localparam logic [31:0] ONE = 32'h0000_0001;
    localparam logic [31:0] CR  = ONE << CONTINUOUS_RX_ENABLE_BIT;
    localparam logic [31:0] SR  = ONE << SINGLE_RX_ENABLE_BIT;
    localparam logic [31:0] AD  = ONE << ADEN_BIT;
    localparam logic [31:0] N9  = ONE << RX9_BIT;
    localparam logic [31:0] FE  = ONE << FRM_BIT;
    localparam logic [31:0] OV  = ONE << OVR_BIT;
    localparam logic [31:0] B8  = ONE << NINTH_BIT;

`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
 errors++; $display("ERROR %s expected %h seen %h", nm, ex, got); end end

    logic              clk, srst, rx_in, sck_in, sck_out, sck_oe;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata, rd;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp, rs;
    logic              awvalid, awready, wvalid, wready, bvalid, bready;
    logic              arvalid, arready, rvalid, rready, rx_char_ready;
    int                errors, cmp_count;

    usart_rx_ctrl #(.BIT_CLKS(BC)) usart_rx_ctrl_i (
        .clk(clk), .srst(srst), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .rx_in(rx_in), .sck_in(sck_in), .sck_out(sck_out),
        .sck_oe(sck_oe), .rx_char_ready(rx_char_ready));

    serial_line_model #(.BIT_CLKS(BC)) serial_line_model_i (
        .clk(clk), .sck_out(sck_out), .sck_oe(sck_oe), .rx_in(rx_in),
        .sck_in(sck_in));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
        end while (!(bvalid && bready) && n < 50);
        rs = bresp;
        bready <= 1'b0;
        if (n >= 50) begin
            errors++;
            $display("ERROR write answer expected 1 seen 0");
        end
    endtask : wr

    task automatic rd_reg(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arvalid && arready)
                arvalid <= 1'b0;
        end while (!(rvalid && rready) && n < 50);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        if (n >= 50) begin
            errors++;
            $display("ERROR read answer expected 1 seen 0");
        end
    endtask : rd_reg

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        rd_reg(a);
        `CHK($sformatf("reg %h", a), e, rd)
    endtask : rchk

    // one edge first so a buffer emptied by the last read is seen empty
    task automatic wait_rdy;
        int n;
        n = 0;
        @(posedge clk);
        while (rx_char_ready !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        `CHK("char ready", 1'b1, rx_char_ready)
    endtask : wait_rdy

    task automatic no_char(input int cycles);
        repeat (cycles) @(posedge clk);
        `CHK("char ready", 1'b0, rx_char_ready)
    endtask : no_char

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        $display("ERROR watchdog expected end seen timeout");
        end_of_test();
    end

    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'h1;
        errors = 0;
        cmp_count = 0;
        srst = 1'b1;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        rchk(CTRL_OFS, 32'h0);
        rchk(MODE_OFS, 32'h0);
        wr(8'h40, CR);
        `CHK("unmapped write resp", RESP_SLVERR, rs)
        rd_reg(8'h40);
        `CHK("unmapped read resp", RESP_SLVERR, rs)
        rchk(CTRL_OFS, 32'h0);
        serial_line_model_i.send_async(9'h099, 8, 1'b1);
        no_char(4);
        wr(CTRL_OFS, CR);
        serial_line_model_i.send_async(9'h05A, 8, 1'b1);
        wait_rdy();
        rchk(STAT_OFS, ONE << FULL_BIT);
        rchk(DATA_OFS, 32'h0000_005A);
        serial_line_model_i.send_async(9'h0C3, 8, 1'b1);
        wait_rdy();
        rchk(DATA_OFS, 32'h0000_00C3);
        // framing flag stays with the character until the next one lands
        serial_line_model_i.send_async(9'h03C, 8, 1'b0);
        wait_rdy();
        rchk(CTRL_OFS, CR | FE);
        rchk(DATA_OFS, 32'h0000_003C);
        rchk(CTRL_OFS, CR | FE);
        serial_line_model_i.send_async(9'h011, 8, 1'b1);
        wait_rdy();
        rchk(CTRL_OFS, CR);
        rchk(DATA_OFS, 32'h0000_0011);
        // second character arrives on a full buffer
        serial_line_model_i.send_async(9'h021, 8, 1'b1);
        serial_line_model_i.send_async(9'h042, 8, 1'b1);
        rchk(CTRL_OFS, CR | OV);
        rchk(DATA_OFS, 32'h0000_0021);
        rchk(CTRL_OFS, CR | OV);
        wr(CTRL_OFS, 32'h0);
        rchk(CTRL_OFS, 32'h0);
        rchk(STAT_OFS, 32'h0);
        wr(CTRL_OFS, CR | N9 | AD);
        serial_line_model_i.send_async(9'h055, 9, 1'b1);
        no_char(4);
        serial_line_model_i.send_async(9'h1A6, 9, 1'b1);
        wait_rdy();
        rchk(CTRL_OFS, CR | N9 | AD | B8);
        rchk(DATA_OFS, 32'h0000_01A6);
        wr(CTRL_OFS, CR | N9);
        serial_line_model_i.send_async(9'h077, 9, 1'b1);
        wait_rdy();
        rchk(CTRL_OFS, CR | N9);
        rchk(DATA_OFS, 32'h0000_0077);
        wr(CTRL_OFS, 32'h0);
        wr(MODE_OFS, (ONE << SYNC_BIT) | (ONE << MASTER_BIT));
        `CHK("clock drive", 1'b1, sck_oe)
        serial_line_model_i.sync_load(16'h0096, 8);
        wr(CTRL_OFS, SR);
        wait_rdy();
        rchk(CTRL_OFS, 32'h0);
        rchk(DATA_OFS, 32'h0000_0096);
        no_char(40);
        serial_line_model_i.sync_load(16'hE718, 16);
        wr(CTRL_OFS, CR | SR);
        wait_rdy();
        rchk(DATA_OFS, 32'h0000_0018);
        wait_rdy();
        rchk(DATA_OFS, 32'h0000_00E7);
        rchk(CTRL_OFS, CR | SR);
        wr(CTRL_OFS, 32'h0);
        no_char(40);
        wr(MODE_OFS, ONE << SYNC_BIT);
        `CHK("clock drive", 1'b0, sck_oe)
        wr(CTRL_OFS, SR);
        serial_line_model_i.send_slave(8'h5B);
        no_char(4);
        wr(CTRL_OFS, CR);
        serial_line_model_i.send_slave(8'hA4);
        wait_rdy();
        rchk(DATA_OFS, 32'h0000_00A4);
        end_of_test();
    end
endmodule : usart_receive_control_status_test
